// file: core/pwc_defines.vh
// Register map, field positions, reset values and counts of the pulse unit
`ifndef PWC_DEFINES_VH
`define PWC_DEFINES_VH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define PWC_ADDR_W 3
`define PWC_OFF_CTRL 3'h0
`define PWC_OFF_PERIOD 3'h1
`define PWC_OFF_DUTY_LOW 3'h2
`define PWC_OFF_DUTY_SHADOW 3'h3
`define PWC_OFF_TIMER_CTRL 3'h4
`define PWC_OFF_TIMER_COUNT 3'h5
`define PWC_OFF_PORT 3'h6
`define PWC_OFF_STATUS 3'h7

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define PWC_CTRL_DLSB_HI 5
`define PWC_CTRL_DLSB_LO 4
`define PWC_CTRL_MODE_HI 3
`define PWC_CTRL_MODE_LO 2
`define PWC_MODE_PWM 2'h3
`define PWC_TCTRL_PRE_HI 1
`define PWC_TCTRL_PRE_LO 0
`define PWC_TCTRL_ON 2
`define PWC_TCTRL_POST_HI 6
`define PWC_TCTRL_POST_LO 3
`define PWC_PORT_LATCH 0
`define PWC_PORT_DIR 1
`define PWC_STATUS_POST 0

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define PWC_RST_CTRL 8'h00
`define PWC_RST_PERIOD 8'hff
`define PWC_RST_DUTY 8'h00
`define PWC_RST_TCTRL 8'h00
`define PWC_RST_PORT 8'h02

// ---------------------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------------------
`define PWC_Q_LAST 2'h3
`define PWC_PRE_SEL_1 2'h0
`define PWC_PRE_SEL_4 2'h1
`define PWC_PRE_LAST_1 4'h0
`define PWC_PRE_LAST_4 4'h3
`define PWC_PRE_LAST_16 4'hf

`endif

// file: core/pwc_pulse_unit.v
// Timer-based pulse-width output of a capture/compare unit
`timescale 1ns/100ps
`include "pwc_defines.vh"
// ---------------------------------------------------------------------------
// Overview of operation
// - The unit drives a pulse-width output with up to 10-bit duty steps.
// - Writing zero to the whole control register forces the pulse latch low.
// - Period is (period_register + 1) x 4 oscillator clocks x prescale.
// - When the timer equals the period value it clears on next increment.
// - At that increment the low duty is copied into the shadow register.
// - At that increment the pin goes high unless the new duty is zero.
// - The postscaler plays no part in the output period.
// - Duty is low register as eight high bits and control bits 5:4 below.
// - High time is the 10-bit duty x one oscillator clock x prescale.
// - Duty writes may come any time but only act after a period match.
// - In pulse mode the shadow register ignores software writes.
// - Shadow plus a 2-bit latch double buffer duty so no glitch appears.
// - Pin clears when shadow duty equals timer extended by two low bits.
// - A duty longer than the period leaves the pin high all period.
// - Usable resolution is log2 of 4 x (period_register + 1) duty steps per period.
// ---------------------------------------------------------------------------

module pwc_pulse_unit (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Register port
	input wire [`PWC_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Output pin
	output reg pulse_out_pin_o,
	output reg pulse_out_pin_oe
);

// ---------------------------------------------------------------------------
// Register state
// ---------------------------------------------------------------------------
reg [7:0] compare_unit_control_q;
reg [7:0] period_register_q;
reg [7:0] duty_low_register_q;
reg [7:0] duty_shadow_register_q;
reg [7:0] timer_control_q;
reg [7:0] period_timer_count_q;
reg port_c_latch_q;
reg port_c_direction_q;
reg post_flag_q;

// ---------------------------------------------------------------------------
// Time base state
// ---------------------------------------------------------------------------
reg [1:0] q_phase_q;
reg [3:0] pre_cnt_q;
reg [3:0] post_cnt_q;
reg [1:0] duty_lsb_latch_q;
reg pwm_latch_q;

// ---------------------------------------------------------------------------
// Decode
// ---------------------------------------------------------------------------
wire wr_ctrl;
wire wr_period;
wire wr_duty_low;
wire wr_shadow;
wire wr_tctrl;
wire wr_count;
wire wr_port;
wire wr_status;

assign wr_ctrl = reg_wr && (reg_addr == `PWC_OFF_CTRL);
assign wr_period = reg_wr && (reg_addr == `PWC_OFF_PERIOD);
assign wr_duty_low = reg_wr && (reg_addr == `PWC_OFF_DUTY_LOW);
assign wr_shadow = reg_wr && (reg_addr == `PWC_OFF_DUTY_SHADOW);
assign wr_tctrl = reg_wr && (reg_addr == `PWC_OFF_TIMER_CTRL);
assign wr_count = reg_wr && (reg_addr == `PWC_OFF_TIMER_COUNT);
assign wr_port = reg_wr && (reg_addr == `PWC_OFF_PORT);
assign wr_status = reg_wr && (reg_addr == `PWC_OFF_STATUS);

// ---------------------------------------------------------------------------
// Derived controls
// ---------------------------------------------------------------------------
wire pwm_mode;
wire timer_on;
wire [1:0] pre_sel;
wire [3:0] post_sel;
wire [1:0] duty_lsb_wr;
wire [9:0] duty_next;
wire duty_next_zero;

assign pwm_mode = compare_unit_control_q[`PWC_CTRL_MODE_HI:`PWC_CTRL_MODE_LO]
	== `PWC_MODE_PWM;
assign timer_on = timer_control_q[`PWC_TCTRL_ON];
assign pre_sel = timer_control_q[`PWC_TCTRL_PRE_HI:`PWC_TCTRL_PRE_LO];
assign post_sel = timer_control_q[`PWC_TCTRL_POST_HI:`PWC_TCTRL_POST_LO];
assign duty_lsb_wr =
	compare_unit_control_q[`PWC_CTRL_DLSB_HI:`PWC_CTRL_DLSB_LO];
assign duty_next = {duty_low_register_q, duty_lsb_wr};
assign duty_next_zero = (duty_next == 10'h000);

// ---------------------------------------------------------------------------
// Prescale and timer ticks
// ---------------------------------------------------------------------------
reg [3:0] pre_last;
reg [1:0] ext_bits;
wire instr_tick;
wire pre_wrap;
wire tmr_inc;
wire period_match;
wire period_restart;
wire duty_hit;

assign instr_tick = (q_phase_q == `PWC_Q_LAST);

always @* begin
	pre_last = `PWC_PRE_LAST_16;
	ext_bits = pre_cnt_q[3:2];
	case (pre_sel)
		`PWC_PRE_SEL_1: begin
			pre_last = `PWC_PRE_LAST_1;
			ext_bits = q_phase_q;
		end
		`PWC_PRE_SEL_4: begin
			pre_last = `PWC_PRE_LAST_4;
			ext_bits = pre_cnt_q[1:0];
		end
		default: begin
			pre_last = `PWC_PRE_LAST_16;
			ext_bits = pre_cnt_q[3:2];
		end
	endcase
end

assign pre_wrap = (pre_cnt_q == pre_last);
assign tmr_inc = instr_tick && timer_on && pre_wrap;
assign period_match = (period_timer_count_q == period_register_q);
assign period_restart = tmr_inc && period_match;

assign duty_hit = ({duty_shadow_register_q, duty_lsb_latch_q}
	== {period_timer_count_q, ext_bits});

// ---------------------------------------------------------------------------
// Quarter phase and prescaler
// ---------------------------------------------------------------------------
always @(posedge core_clk or negedge nrst) begin
	if (!nrst) begin
		q_phase_q <= 2'h0;
		pre_cnt_q <= 4'h0;
	end else begin
		q_phase_q <= q_phase_q + 2'h1;
		if (wr_tctrl) begin
			pre_cnt_q <= 4'h0;
		end else if (instr_tick && timer_on) begin
			pre_cnt_q <= pre_wrap ? 4'h0 : pre_cnt_q + 4'h1;
		end
	end
end

// ---------------------------------------------------------------------------
// Timer count
// ---------------------------------------------------------------------------
always @(posedge core_clk or negedge nrst) begin
	if (!nrst) begin
		period_timer_count_q <= 8'h00;
	end else if (wr_count) begin
		period_timer_count_q <= reg_wdata;
	end else if (tmr_inc) begin
		period_timer_count_q <= period_match ? 8'h00
			: period_timer_count_q + 8'h01;
	end
end

// ---------------------------------------------------------------------------
// Software registers
// ---------------------------------------------------------------------------
localparam [7:0] port_rst_val = `PWC_RST_PORT;

always @(posedge core_clk or negedge nrst) begin
	if (!nrst) begin
		compare_unit_control_q <= `PWC_RST_CTRL;
		period_register_q <= `PWC_RST_PERIOD;
		duty_low_register_q <= `PWC_RST_DUTY;
		timer_control_q <= `PWC_RST_TCTRL;
		port_c_latch_q <= port_rst_val[`PWC_PORT_LATCH];
		port_c_direction_q <= port_rst_val[`PWC_PORT_DIR];
	end else begin
		if (wr_ctrl) begin
			compare_unit_control_q <= reg_wdata;
		end
		if (wr_period) begin
			period_register_q <= reg_wdata;
		end
		if (wr_duty_low) begin
			duty_low_register_q <= reg_wdata;
		end
		if (wr_tctrl) begin
			timer_control_q <= reg_wdata;
		end
		if (wr_port) begin
			port_c_latch_q <= reg_wdata[`PWC_PORT_LATCH];
			port_c_direction_q <= reg_wdata[`PWC_PORT_DIR];
		end
	end
end

// ---------------------------------------------------------------------------
// Duty double buffer
// ---------------------------------------------------------------------------
// In pulse mode loading only at period end keeps a half-written duty off the pin.
always @(posedge core_clk or negedge nrst) begin
	if (!nrst) begin
		duty_shadow_register_q <= `PWC_RST_DUTY;
		duty_lsb_latch_q <= 2'h0;
	end else if (period_restart) begin
		duty_shadow_register_q <= duty_low_register_q;
		duty_lsb_latch_q <= duty_lsb_wr;
	end else if (wr_shadow && !pwm_mode) begin
		duty_shadow_register_q <= reg_wdata;
	end
end

// ---------------------------------------------------------------------------
// Pulse latch
// ---------------------------------------------------------------------------
always @(posedge core_clk or negedge nrst) begin
	if (!nrst) begin
		pwm_latch_q <= 1'b0;
	end else if (wr_ctrl && (reg_wdata == 8'h00)) begin
		pwm_latch_q <= 1'b0;
	end else if (pwm_mode && period_restart) begin
		pwm_latch_q <= !duty_next_zero;
	end else if (pwm_mode && duty_hit) begin
		pwm_latch_q <= 1'b0;
	end
end

// ---------------------------------------------------------------------------
// Postscaler
// ---------------------------------------------------------------------------
// Only raises a status flag; it never reaches the period logic.
always @(posedge core_clk or negedge nrst) begin
	if (!nrst) begin
		post_cnt_q <= 4'h0;
		post_flag_q <= 1'b0;
	end else begin
		if (period_restart) begin
			post_cnt_q <= (post_cnt_q == post_sel) ? 4'h0
				: post_cnt_q + 4'h1;
		end
		// Set beats a clear in the same cycle
		if (period_restart && (post_cnt_q == post_sel)) begin
			post_flag_q <= 1'b1;
		end else if (wr_status && reg_wdata[`PWC_STATUS_POST]) begin
			post_flag_q <= 1'b0;
		end
	end
end

// ---------------------------------------------------------------------------
// Pin drive
// ---------------------------------------------------------------------------
always @(posedge core_clk or negedge nrst) begin
	if (!nrst) begin
		pulse_out_pin_o <= 1'b0;
		pulse_out_pin_oe <= 1'b0;
	end else begin
		// Compare cycle shows low, else high time runs one long
		pulse_out_pin_o <= pwm_mode ? (pwm_latch_q && !duty_hit)
			: port_c_latch_q;
		pulse_out_pin_oe <= !port_c_direction_q;
	end
end

// ---------------------------------------------------------------------------
// Read port
// ---------------------------------------------------------------------------
reg [7:0] rd_mux;

always @* begin
	rd_mux = 8'h00;
	case (reg_addr)
		`PWC_OFF_CTRL: begin
			rd_mux = compare_unit_control_q;
		end
		`PWC_OFF_PERIOD: begin
			rd_mux = period_register_q;
		end
		`PWC_OFF_DUTY_LOW: begin
			rd_mux = duty_low_register_q;
		end
		`PWC_OFF_DUTY_SHADOW: begin
			rd_mux = duty_shadow_register_q;
		end
		`PWC_OFF_TIMER_CTRL: begin
			rd_mux = timer_control_q;
		end
		`PWC_OFF_TIMER_COUNT: begin
			rd_mux = period_timer_count_q;
		end
		`PWC_OFF_PORT: begin
			rd_mux = {5'h00, pwm_latch_q, port_c_direction_q,
				port_c_latch_q};
		end
		`PWC_OFF_STATUS: begin
			rd_mux = {7'h00, post_flag_q};
		end
		default: begin
			rd_mux = 8'h00;
		end
	endcase
end

// Data held between reads so a stale strobe never shows garbage
always @(posedge core_clk or negedge nrst) begin
	if (!nrst) begin
		reg_rdata <= 8'h00;
	end else if (reg_rd) begin
		reg_rdata <= rd_mux;
	end
end

endmodule // pwc_pulse_unit

// file: verification/pwc_load_model.sv
// Load on the pulse pin, measuring high time and period
`timescale 1ns/100ps
module pwc_load_model (
	// Clock
	input wire core_clk,
	// Pin
	input wire pin_o,
	input wire pin_oe,
	// Measured lengths
	output reg [15:0] hi_len,
	output reg [15:0] per_len
);
	wire lvl = pin_oe & pin_o;
	reg lvl_q = 1'b0;
	reg [15:0] hi_cnt = 16'h0;
	reg [15:0] per_cnt = 16'h0;
	initial begin
		hi_len = 16'h0;
		per_len = 16'h0;
	end
	always @(posedge core_clk) begin
		lvl_q <= lvl;
		hi_cnt <= lvl ? hi_cnt + 16'h1 : 16'h0;
		per_cnt <= (lvl && !lvl_q) ? 16'h1 : per_cnt + 16'h1;
		if (lvl && !lvl_q)
			per_len <= per_cnt;
		if (!lvl && lvl_q)
			hi_len <= hi_cnt;
	end
endmodule // pwc_load_model

// file: verification/pwc_pulse_unit_assertions.sv
// Port checker of the pulse unit
`timescale 1ns/100ps
module pwc_pulse_unit_assertions (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Register port
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// Output pin
	input wire pulse_out_pin_o,
	input wire pulse_out_pin_oe
);
	reg [7:0] per_q;
	reg [7:0] duty_q;
	reg [1:0] lsb_q;
	reg on_q;
	wire [9:0] dty = {duty_q, lsb_q};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ----
	// Copy of written registers
	// ----
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			per_q <= 8'hff;
			duty_q <= 8'h00;
			lsb_q <= 2'h0;
			on_q <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == 3'h1)
				per_q <= reg_wdata;
			if (reg_addr == 3'h2)
				duty_q <= reg_wdata;
			if (reg_addr == 3'h0)
				lsb_q <= reg_wdata[5:4];
			if (reg_addr == 3'h4)
				on_q <= reg_wdata[2];
		end
	end
	sequence s_ctrl_zero;
		reg_wr && reg_addr == 3'h0 && reg_wdata == 8'h00;
	endsequence
	sequence s_pin_low;
		!pulse_out_pin_o;
	endsequence
	// ----
	// Assertions
	// ----
	AST_OE_DRIVE: assert property (reg_wr && reg_addr == 3'h6
		&& !reg_wdata[1] |-> ##[1:2] pulse_out_pin_oe)
		else $error("pin not driven after direction clear");
	AST_RST_LOW: assert property ($rose(nrst) |->
		!pulse_out_pin_o && !pulse_out_pin_oe)
		else $error("pin active after reset");
	AST_CTRL_ZERO: assert property (s_ctrl_zero |-> ##2 s_pin_low)
		else $error("pin high after control cleared");
	AST_PER_RD: assert property (reg_rd && reg_addr == 3'h1
		|=> reg_rdata == per_q)
		else $error("period readback wrong");
	AST_DUTY_RD: assert property (reg_rd && reg_addr == 3'h2
		|=> reg_rdata == duty_q)
		else $error("duty readback wrong");
	AST_LSB_RD: assert property (reg_rd && reg_addr == 3'h0
		|=> reg_rdata[5:4] == lsb_q)
		else $error("duty low bits readback wrong");
	AST_ZERO_DUTY: assert property ($rose(pulse_out_pin_o) |->
		$past(dty, 2) != 10'h000 || $past(dty, 3) != 10'h000)
		else $error("pin set with zero duty");
	AST_TIMER_OFF: assert property ($changed(pulse_out_pin_o) |->
		on_q || $past(reg_wr, 2) || $past(reg_wr, 3))
		else $error("pin moved with timer stopped");
endmodule // pwc_pulse_unit_assertions

// file: verification/pwc_pulse_unit_test.sv
// Self-checking bench of the pulse unit
`timescale 1ns/100ps
module pwc_pulse_unit_test;
	reg core_clk, nrst, reg_wr, reg_rd;
	reg [2:0] reg_addr;
	reg [7:0] reg_wdata, v, r;
	wire [7:0] reg_rdata;
	wire pin_o, pin_oe;
	wire [15:0] hi_len, per_len;
	integer err_count = 0;
	integer samples_checked = 0;
	integer cyc = 0;
	integer seed, i, p, d, s;
	reg hi_any, lo_any;
	pwc_pulse_unit i_dut (.core_clk(core_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pulse_out_pin_o(pin_o), .pulse_out_pin_oe(pin_oe));
	pwc_load_model i_load (.core_clk(core_clk), .pin_o(pin_o),
		.pin_oe(pin_oe), .hi_len(hi_len), .per_len(per_len));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// ----
	// Helpers
	// ----
	function integer pre_f(input integer sel);
		pre_f = (sel == 0) ? 1 : (sel == 1) ? 4 : 16;
	endfunction
	function [7:0] rst_f(input [2:0] a);
		rst_f = (a == 3'h1) ? 8'hff : (a == 3'h6) ? 8'h02 : 8'h00;
	endfunction
	task chk(input [15:0] seen, input [15:0] exp, input string nm);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input [2:0] a, input [7:0] x);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [2:0] a, output [7:0] x);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		x = reg_rdata;
	endtask
	// Random postscale must not touch the period
	task cfg(input [1:0] ps, input [7:0] pp, input [9:0] dd);
		r = $random(seed);
		wr(3'h1, pp);
		wr(3'h2, dd[9:2]);
		wr(3'h0, {2'h0, dd[1:0], 4'hc});
		wr(3'h4, {1'b0, r[3:0], 1'b1, ps});
		wr(3'h5, 8'h00);
	endtask
	task watch(input integer n);
		hi_any = 1'b0;
		lo_any = 1'b0;
		repeat (n) begin
			@(negedge core_clk);
			hi_any = hi_any | (pin_oe & pin_o);
			lo_any = lo_any | !(pin_oe & pin_o);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard, run needs at most about 11000 cycles
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			err_count = err_count + 1;
			give_verdict;
		end
	end
	// ----
	// Tests
	// ----
	initial begin
		seed = 32'h87acdb64;
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		for (i = 0; i < 8; i = i + 1) begin
			rd(i[2:0], v);
			chk(v, rst_f(i[2:0]), "reset value");
		end
		chk(pin_oe, 1'b0, "reset enable");
		$display("test 1 done");
		wr(3'h6, 8'h00);
		for (i = 0; i < 6; i = i + 1) begin
			s = i % 3;
			p = $random(seed) & 7;
			d = ($random(seed) & 1023) % (4 * p + 3) + 1;
			if (i == 0)
				p = 255;
			if (i == 0)
				d = 1023;
			cfg(s[1:0], p[7:0], d[9:0]);
			repeat (12 * (p + 1) * pre_f(s) + 40) @(posedge core_clk);
			chk(per_len, 4 * (p + 1) * pre_f(s), "period");
			chk(hi_len, d * pre_f(s), "high");
		end
		$display("test 2 done");
		cfg(2'h0, 8'h03, 10'h000);
		repeat (40) @(posedge core_clk);
		watch(64);
		chk(hi_any, 1'b0, "zero duty");
		cfg(2'h0, 8'h03, 10'h3ff);
		repeat (40) @(posedge core_clk);
		watch(64);
		chk(lo_any, 1'b0, "long duty");
		$display("test 3 done");
		cfg(2'h0, 8'hff, 10'h200);
		repeat (1100) @(posedge core_clk);
		wr(3'h3, 8'h5a);
		rd(3'h3, v);
		chk(v, 8'h80, "shadow write");
		wr(3'h2, 8'h11);
		wr(3'h0, 8'h3c);
		rd(3'h2, v);
		chk(v, 8'h11, "duty readback");
		rd(3'h0, v);
		chk(v, 8'h3c, "control readback");
		rd(3'h3, v);
		chk(v, 8'h80, "shadow held");
		repeat (2100) @(posedge core_clk);
		rd(3'h3, v);
		chk(v, 8'h11, "shadow load");
		chk(hi_len, 16'd71, "low bits");
		$display("test 4 done");
		wr(3'h0, 8'h00);
		rd(3'h6, v);
		chk(v, 8'h00, "latch cleared");
		chk(pin_o, 1'b0, "pin cleared");
		$display("test 5 done");
		give_verdict;
	end
endmodule // pwc_pulse_unit_test
bind pwc_pulse_unit pwc_pulse_unit_assertions i_chk (.core_clk(core_clk),
	.nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pulse_out_pin_o(pulse_out_pin_o), .pulse_out_pin_oe(pulse_out_pin_oe));
